// >>> rtl/tuner_pkg.sv
package tuner_pkg;

    // Register indices on the serial link.
    localparam logic [3:0] ADDR_PART_CODE = 4'h0;
    localparam logic [3:0] ADDR_REVISION = 4'h1;
    localparam logic [3:0] ADDR_POWER = 4'h2;
    localparam logic [3:0] ADDR_FIRST_RW = 4'h2;
    localparam logic [3:0] ADDR_AUDIO_BIAS = 4'h7;
    localparam logic [3:0] ADDR_LAST_RW = 4'h9;
    localparam logic [3:0] ADDR_STATUS = 4'ha;
    localparam logic [3:0] ADDR_CURRENT_CHANNEL_READBACK = 4'hb;
    localparam logic [3:0] ADDR_RDS_A = 4'hc;
    localparam logic [3:0] ADDR_RDS_B = 4'hd;
    localparam logic [3:0] ADDR_RDS_C = 4'he;
    localparam logic [3:0] ADDR_RDS_D = 4'hf;

    // Field positions.
    localparam int ENABLE_BIT = 0;
    localparam int DISABLE_BIT = 6;
    localparam int RDS_VERBOSE_BIT = 11;
    localparam int AUDIO_BIAS_BIT = 14;

    // Error-rate fields that only verbose mode may show.
    localparam logic [15:0] STATUS_ERROR_RATE_MASK = 16'h0600;
    localparam logic [15:0] CURRENT_CHANNEL_READBACK_ERROR_RATE_MASK = 16'hfc00;

    // Reset value of every writable register.
    localparam logic [15:0] REG_RESET_VALUE = 16'h0000;

    // Three-wire framing: chip address and bit counts.
    localparam logic [3:0] CHIP_ADDRESS = 4'h6;
    localparam logic [4:0] LAST_CTRL_BIT = 5'h08;
    localparam logic [4:0] LAST_DATA_BIT = 5'h0f;
    localparam logic [4:0] DATA_BIT_COUNT = 5'h10;

    // Timing at a 25 ns system clock.
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int POWERUP_TIME_NS = 2000;
    localparam int POWERDOWN_TIME_NS = 1000;
    localparam int POWERUP_CYCLES = (POWERUP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int POWERDOWN_CYCLES = (POWERDOWN_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Identity words; the values are arbitrary.
    localparam logic [15:0] PART_CODE_VALUE = 16'h5a5a;
    localparam logic [15:0] REVISION_UP_VALUE = 16'h3c3c;
    localparam logic [15:0] REVISION_DOWN_VALUE = 16'h3c00;

    typedef logic [15:0] reg_word_type;
    typedef logic [15:0][15:0] reg_image_type;

    // Power sequencing states.
    typedef enum logic [2:0] {
        POWER_OFF,
        POWERING_UP,
        POWERED_UP,
        POWERING_DOWN,
        POWERED_DOWN
    } power_state_type;

    // One register write carried from the link to the core.
    typedef struct packed {
        logic [3:0] addr;
        reg_word_type data;
    } link_write_type;

    // Bus-select straps.
    typedef struct packed {
        logic serial_enable;
        logic strap_one;
        logic strap_three;
    } strap_type;

    // Audio output drive for both channels.
    typedef struct packed {
        logic left_common_mode;
        logic left_bias_hold;
        logic right_common_mode;
        logic right_bias_hold;
    } audio_drive_type;

    // Read-only words from the tuning and RDS datapath.
    typedef struct packed {
        reg_word_type status_word;
        reg_word_type current_channel_readback_word;
        reg_word_type block_a;
        reg_word_type block_b;
        reg_word_type block_c;
        reg_word_type block_d;
    } rds_status_type;

endpackage : tuner_pkg

// >>> rtl/tuner_serial_link.sv
`timescale 1ns/1ps
`default_nettype none
// Three-wire serial engine on the serial clock.
module tuner_serial_link (
    // Link clock and reset.
    input wire logic serial_clock,
    input wire logic rst,
    // Level from the core: link may run.
    input wire logic link_enable,
    // Serial pins.
    input wire logic serial_enable_pin_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    // Write handoff to the core.
    output logic write_toggle,
    output tuner_pkg::link_write_type write_word,
    // Register image handoff from the core.
    input wire logic snap_req,
    output logic snap_ack,
    input wire tuner_pkg::reg_image_type snap_image
);

    // Transfer phases.
    typedef enum logic [2:0] {
        L_IDLE,
        L_CTRL,
        L_WRITE,
        L_READ,
        L_DONE
    } link_phase_type;

    // Whole state of the link side.
    typedef struct packed {
        logic ena_s1;
        logic ena_s2;
        link_phase_type phase;
        logic [4:0] count;
        logic [15:0] shift;
        logic [3:0] addr;
        logic wr_toggle;
        tuner_pkg::link_write_type wr_word;
        logic req_s1;
        logic req_s2;
        logic ack;
        tuner_pkg::reg_image_type image;
        logic out;
        logic oe;
    } link_state_type;

    link_state_type state;
    link_state_type next_state;
    logic [8:0] ctrl_word; // Assembled control word.

    // Next-state logic: synchronisers, image capture and the bit engine.
    always_comb begin
        next_state = state;
        ctrl_word = {state.shift[7:0], sdio_in};
        next_state.ena_s1 = link_enable;
        next_state.ena_s2 = state.ena_s1;
        next_state.req_s1 = snap_req;
        next_state.req_s2 = state.req_s1;
        // The core holds the image still until it sees our acknowledge.
        if (state.req_s2 != state.ack) begin
            next_state.image = snap_image;
            next_state.ack = state.req_s2;
        end
        // A high enable pin, or a disabled link, ends any transfer.
        if (serial_enable_pin_n || !state.ena_s2) begin
            next_state.phase = L_IDLE;
            next_state.oe = 1'b0;
        end else begin
            unique case (state.phase)
                L_IDLE: begin
                    // First control bit is taken on the start edge.
                    next_state.shift = {state.shift[14:0], sdio_in};
                    next_state.count = 5'h01;
                    next_state.phase = L_CTRL;
                end
                L_CTRL: begin
                    next_state.shift = {state.shift[14:0], sdio_in};
                    next_state.count = state.count + 5'h01;
                    if (state.count == tuner_pkg::LAST_CTRL_BIT) begin
                        next_state.count = 5'h00;
                        next_state.addr = ctrl_word[3:0];
                        // Another chip's address: sit out the transfer.
                        if ({ctrl_word[8:6], ctrl_word[4]} != tuner_pkg::CHIP_ADDRESS) begin
                            next_state.phase = L_DONE;
                        end else if (ctrl_word[5]) begin
                            next_state.shift = state.image[ctrl_word[3:0]];
                            next_state.phase = L_READ;
                        end else begin
                            next_state.phase = L_WRITE;
                        end
                    end
                end
                L_WRITE: begin
                    next_state.shift = {state.shift[14:0], sdio_in};
                    next_state.count = state.count + 5'h01;
                    if (state.count == tuner_pkg::LAST_DATA_BIT) begin
                        next_state.wr_word = {state.addr, state.shift[14:0], sdio_in};
                        next_state.wr_toggle = ~state.wr_toggle;
                        next_state.phase = L_DONE;
                    end
                end
                L_READ: begin
                    // Half-cycle turnaround, then one bit per rising edge.
                    if (state.count == tuner_pkg::DATA_BIT_COUNT) begin
                        next_state.oe = 1'b0;
                        next_state.phase = L_DONE;
                    end else begin
                        next_state.out = state.shift[15];
                        next_state.oe = 1'b1;
                        next_state.shift = {state.shift[14:0], 1'b0};
                        next_state.count = state.count + 5'h01;
                    end
                end
                L_DONE: begin
                    next_state.oe = 1'b0;
                end
            endcase
        end
    end

    // State register on the serial clock.
    always_ff @(posedge serial_clock or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sdio_out = state.out;
    assign sdio_oe = state.oe;
    assign write_toggle = state.wr_toggle;
    assign write_word = state.wr_word;
    assign snap_ack = state.ack;

endmodule : tuner_serial_link
`default_nettype wire

// >>> rtl/tuner_power_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Register bank and power sequencing of the tuner.
module tuner_power_regs #(
    parameter int POWERUP_CYCLES = tuner_pkg::POWERUP_CYCLES,
    parameter int POWERDOWN_CYCLES = tuner_pkg::POWERDOWN_CYCLES,
    parameter int TIMER_WIDTH = 16
) (
    // System clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Serial link clock.
    input wire logic serial_clock,
    // Chip reset pin and bus straps.
    input wire logic reset_pin_n,
    input wire logic serial_enable_pin_n,
    input wire logic bus_strap_pin_one,
    input wire logic bus_strap_pin_three,
    // Serial data pin.
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    // Datapath status inputs.
    input wire tuner_pkg::rds_status_type rds_status,
    // Block outputs.
    output logic powered_up,
    output logic bus_two_wire,
    output tuner_pkg::audio_drive_type audio_drive,
    output tuner_pkg::reg_image_type control_regs
);

    // Refuse timer settings that the counter cannot hold.
    if (POWERUP_CYCLES < 1 || POWERDOWN_CYCLES < 1 ||
        POWERUP_CYCLES >= (1 << TIMER_WIDTH) || POWERDOWN_CYCLES >= (1 << TIMER_WIDTH)) begin : g_check
        $error("Power timer counts do not fit the timer width.");
    end

    // Timer loads at the counter's width.
    localparam logic [TIMER_WIDTH-1:0] UP_LOAD = TIMER_WIDTH'(POWERUP_CYCLES - 1);
    localparam logic [TIMER_WIDTH-1:0] DOWN_LOAD = TIMER_WIDTH'(POWERDOWN_CYCLES - 1);

    // Whole state of the core.
    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        tuner_pkg::strap_type strap_s1;
        tuner_pkg::strap_type strap_s2;
        logic two_wire;
        logic link_enable;
        logic wr_s1;
        logic wr_s2;
        logic wr_s3;
        logic ack_s1;
        logic ack_s2;
        logic snap_req;
        tuner_pkg::reg_image_type launch;
        tuner_pkg::reg_image_type regs;
        tuner_pkg::power_state_type power;
        logic [TIMER_WIDTH-1:0] timer;
        tuner_pkg::audio_drive_type audio;
    } core_state_type;

    core_state_type state;
    core_state_type next_state;
    tuner_pkg::reg_image_type image_view; // Registers as the host reads them.
    logic write_toggle; // Toggles once per link write.
    tuner_pkg::link_write_type write_word; // Held by the link after each toggle.
    logic snap_ack; // Link's acknowledge of the image.
    logic write_event; // One cycle per link write.
    logic pin_rise; // Reset pin release seen.
    logic bias_wanted; // Host asks for the output bias.
    logic in_powerup; // Outputs at common mode.

    // Serial engine on the link clock.
    tuner_serial_link u_link (
        .serial_clock(serial_clock),
        .rst(rst),
        .link_enable(state.link_enable),
        .serial_enable_pin_n(serial_enable_pin_n),
        .sdio_in(sdio_in),
        .sdio_out(sdio_out),
        .sdio_oe(sdio_oe),
        .write_toggle(write_toggle),
        .write_word(write_word),
        .snap_req(state.snap_req),
        .snap_ack(snap_ack),
        .snap_image(state.launch)
    );

    // Read view: identity words, stored registers and masked status.
    always_comb begin
        image_view = state.regs;
        image_view[tuner_pkg::ADDR_PART_CODE] = tuner_pkg::PART_CODE_VALUE;
        // Revision word reports powered fields only while enabled.
        if (state.regs[tuner_pkg::ADDR_POWER][tuner_pkg::ENABLE_BIT]) begin
            image_view[tuner_pkg::ADDR_REVISION] = tuner_pkg::REVISION_UP_VALUE;
        end else begin
            image_view[tuner_pkg::ADDR_REVISION] = tuner_pkg::REVISION_DOWN_VALUE;
        end
        image_view[tuner_pkg::ADDR_STATUS] = rds_status.status_word;
        image_view[tuner_pkg::ADDR_CURRENT_CHANNEL_READBACK] = rds_status.current_channel_readback_word;
        // Error-rate fields stay zero unless verbose mode is chosen.
        if (!state.regs[tuner_pkg::ADDR_POWER][tuner_pkg::RDS_VERBOSE_BIT]) begin
            image_view[tuner_pkg::ADDR_STATUS] = rds_status.status_word & ~tuner_pkg::STATUS_ERROR_RATE_MASK;
            image_view[tuner_pkg::ADDR_CURRENT_CHANNEL_READBACK] = rds_status.current_channel_readback_word & ~tuner_pkg::CURRENT_CHANNEL_READBACK_ERROR_RATE_MASK;
        end
        image_view[tuner_pkg::ADDR_RDS_A] = rds_status.block_a;
        image_view[tuner_pkg::ADDR_RDS_B] = rds_status.block_b;
        image_view[tuner_pkg::ADDR_RDS_C] = rds_status.block_c;
        image_view[tuner_pkg::ADDR_RDS_D] = rds_status.block_d;
    end

    assign write_event = state.wr_s2 ^ state.wr_s3;
    assign pin_rise = state.pin_s2 && !state.pin_prev;

    // Next-state logic: straps, crossings, writes and power sequencing.
    always_comb begin
        next_state = state;
        next_state.pin_s1 = reset_pin_n;
        next_state.pin_s2 = state.pin_s1;
        next_state.pin_prev = state.pin_s2;
        next_state.strap_s1 = {serial_enable_pin_n, bus_strap_pin_one, bus_strap_pin_three};
        next_state.strap_s2 = state.strap_s1;
        next_state.wr_s1 = write_toggle;
        next_state.wr_s2 = state.wr_s1;
        next_state.wr_s3 = state.wr_s2;
        next_state.ack_s1 = snap_ack;
        next_state.ack_s2 = state.ack_s1;
        // Launch a fresh image only once the last one was taken, so
        // the link never samples a word while it changes.
        if (state.ack_s2 == state.snap_req) begin
            next_state.launch = image_view;
            next_state.snap_req = ~state.snap_req;
        end
        if (!state.pin_s2) begin
            // Held reset: registers to defaults, link off.
            next_state.regs = '0;
            next_state.power = tuner_pkg::POWER_OFF;
            next_state.timer = '0;
            next_state.link_enable = 1'b0;
        end else begin
            // Straps count only on the edge where the pin is released.
            if (pin_rise) begin
                if (state.strap_s2.strap_three) begin
                    next_state.two_wire = state.strap_s2.strap_one;
                end else begin
                    // Enable pin sampled high selects two-wire.
                    next_state.two_wire = state.strap_s2.serial_enable;
                end
            end
            // Only the three-wire engine exists; two-wire keeps it idle.
            next_state.link_enable = !state.two_wire && !pin_rise;
            unique case (state.power)
                tuner_pkg::POWERING_UP: begin
                    if (state.timer == '0) begin
                        next_state.power = tuner_pkg::POWERED_UP;
                    end else begin
                        next_state.timer = state.timer - 1'b1;
                    end
                end
                tuner_pkg::POWERING_DOWN: begin
                    // Sequence end clears both bits; the host polls for that.
                    if (state.timer == '0) begin
                        next_state.regs[tuner_pkg::ADDR_POWER][tuner_pkg::ENABLE_BIT] = 1'b0;
                        next_state.regs[tuner_pkg::ADDR_POWER][tuner_pkg::DISABLE_BIT] = 1'b0;
                        next_state.power = tuner_pkg::POWERED_DOWN;
                    end else begin
                        next_state.timer = state.timer - 1'b1;
                    end
                end
                tuner_pkg::POWER_OFF, tuner_pkg::POWERED_UP, tuner_pkg::POWERED_DOWN: begin
                    // Settled states keep every register as it is.
                    next_state.timer = '0;
                end
            endcase
            // A write lands after the sequencer, so it wins a same-cycle clear.
            if (write_event && write_word.addr >= tuner_pkg::ADDR_FIRST_RW &&
                write_word.addr <= tuner_pkg::ADDR_LAST_RW) begin
                next_state.regs[write_word.addr] = write_word.data;
                if (write_word.addr == tuner_pkg::ADDR_POWER && write_word.data[tuner_pkg::ENABLE_BIT]) begin
                    if (!write_word.data[tuner_pkg::DISABLE_BIT]) begin
                        next_state.power = tuner_pkg::POWERING_UP;
                        next_state.timer = UP_LOAD;
                    end else begin
                        next_state.power = tuner_pkg::POWERING_DOWN;
                        next_state.timer = DOWN_LOAD;
                    end
                end
            end
        end
        // Audio drive follows the next power state so it leaves a flop.
        bias_wanted = next_state.regs[tuner_pkg::ADDR_AUDIO_BIAS][tuner_pkg::AUDIO_BIAS_BIT];
        in_powerup = next_state.power == tuner_pkg::POWERING_UP ||
                     next_state.power == tuner_pkg::POWERED_UP ||
                     next_state.power == tuner_pkg::POWERING_DOWN;
        next_state.audio.left_common_mode = in_powerup;
        next_state.audio.right_common_mode = in_powerup;
        next_state.audio.left_bias_hold = !in_powerup && bias_wanted && next_state.pin_s2;
        next_state.audio.right_bias_hold = !in_powerup && bias_wanted && next_state.pin_s2;
    end

    // State register on the system clock.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign powered_up = (state.power == tuner_pkg::POWERED_UP);
    assign bus_two_wire = state.two_wire;
    assign audio_drive = state.audio;
    assign control_regs = state.regs;

endmodule : tuner_power_regs
`default_nettype wire

// >>> verif/tuner_power_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of power sequencing, reset and audio drive.
module tuner_power_regs_asserts #(
    parameter int POWERUP_CYCLES = 3,
    parameter int POWERDOWN_CYCLES = 2
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Pins watched.
    input wire logic reset_pin_n,
    input wire logic sdio_oe,
    // Outputs watched.
    input wire logic powered_up,
    input wire logic bus_two_wire,
    input wire tuner_pkg::audio_drive_type audio_drive,
    input wire tuner_pkg::reg_image_type control_regs
);
    // Margins are slack; both windows open at a register change, after every synchroniser.
    localparam int PU_MAX = POWERUP_CYCLES + 4;
    localparam int PD_MAX = POWERDOWN_CYCLES + 4;

    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_supply_zero: assert property ($fell(rst) |-> (control_regs[2][0] | control_regs[2][6]) == 1'b0)
        else $error("power bits not zero after reset");
    chk_powerup_time: assert property ($rose(control_regs[2][0]) && !control_regs[2][6]
        |-> !powered_up [*2] ##[1:PU_MAX] powered_up) else $error("powerup timing wrong");
    chk_up_enable: assert property (powered_up |-> control_regs[2][0])
        else $error("powered up without enable bit");
    chk_powerdown_clear: assert property ($fell(powered_up)
        |-> ##[1:PD_MAX] (control_regs[2][0] == 1'b0 && control_regs[2][6] == 1'b0))
        else $error("power bits not cleared");
    chk_audio_common: assert property (powered_up |-> audio_drive.left_common_mode
        && audio_drive.right_common_mode && !audio_drive.left_bias_hold) else $error("audio not common mode");
    chk_bias_down: assert property (audio_drive.left_bias_hold |-> !powered_up
        && !audio_drive.left_common_mode && audio_drive.right_bias_hold) else $error("bias hold out of powerdown");
    chk_regs_cleared: assert property (!reset_pin_n [*5] |-> control_regs == '0)
        else $error("registers not cleared");
    chk_link_quiet: assert property (!reset_pin_n [*8] |-> !sdio_oe)
        else $error("data line driven in reset");
    chk_strap_hold: assert property (reset_pin_n [*8] |=> $stable(bus_two_wire))
        else $error("bus mode changed");

    cover property ($rose(powered_up));
    cover property ($rose(audio_drive.left_bias_hold));
    cover property ($rose(bus_two_wire));
endmodule : tuner_power_regs_asserts

bind tuner_power_regs tuner_power_regs_asserts #(
    .POWERUP_CYCLES(POWERUP_CYCLES),
    .POWERDOWN_CYCLES(POWERDOWN_CYCLES)
) tuner_power_regs_asserts_inst (.clock(clock), .rst(rst), .reset_pin_n(reset_pin_n), .sdio_oe(sdio_oe),
    .powered_up(powered_up), .bus_two_wire(bus_two_wire), .audio_drive(audio_drive), .control_regs(control_regs));
`default_nettype wire

// >>> verif/tuner_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the three-wire link; the link clock may run freely.
module tuner_host_model (
    // Link pins.
    output logic serial_clock,
    output logic serial_enable_pin_n,
    output logic host_sdio,
    input wire logic sdio_line
);
    logic [15:0] read_word; // Word of the last read frame.
    logic park_high; // Two-wire strap: clock parked high.
    initial begin
        serial_clock = 1'b0;
        serial_enable_pin_n = 1'b0;
        host_sdio = 1'b1;
        park_high = 1'b0;
        #3;
        forever #15 serial_clock = park_high | ~serial_clock;
    end
    // Sets the select pin, which also serves as a bus strap.
    task automatic set_enable(input logic v);
        serial_enable_pin_n = v;
    endtask : set_enable
    // One frame, then a gap long enough for the snapshot to refresh.
    task automatic xfer(input logic rw, input logic [3:0] addr, input logic [15:0] wdata);
        logic [24:0] frame;
        frame = {3'b011, rw, 1'b0, addr, wdata};
        for (int i = 0; i <= 25; i++) begin
            @(negedge serial_clock);
            if (rw && i >= 10) begin
                read_word[25 - i] = sdio_line;
            end
            // A released line toggles so a stale level is never trusted.
            if (i < 25 && !(rw && i >= 9)) begin
                host_sdio = frame[24 - i];
            end else begin
                host_sdio = ~host_sdio;
            end
            serial_enable_pin_n = (i == 25);
        end
        repeat (24) begin
            @(negedge serial_clock);
            host_sdio = ~host_sdio;
        end
    endtask : xfer
endmodule : tuner_host_model
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock;
    logic rst;
    logic reset_pin_n;
    logic strap_one;
    logic strap_three;
    logic serial_clock;
    logic serial_enable_pin_n;
    logic host_sdio;
    logic sdio_out;
    logic sdio_oe;
    logic powered_up;
    logic bus_two_wire;
    tuner_pkg::audio_drive_type audio_drive;
    tuner_pkg::reg_image_type control_regs;
    tuner_pkg::rds_status_type rds_status;
    wire logic sdio_line;
    int bad_count;
    int tests_run;
    // One ordinary register access and the word it must read back.
    typedef struct {logic [3:0] addr; logic wr; logic [15:0] data; logic [15:0] exp;} row_type;
    row_type rows[7] = '{'{4'h3, 1'b1, 16'h1234, 16'h1234}, '{4'h9, 1'b1, 16'ha5c3, 16'ha5c3},
        '{4'h0, 1'b1, 16'hffff, tuner_pkg::PART_CODE_VALUE}, '{4'h1, 1'b0, 16'h0000, tuner_pkg::REVISION_DOWN_VALUE},
        '{4'hc, 1'b1, 16'h0000, 16'h1111}, '{4'ha, 1'b1, 16'h0000, 16'hffff & ~tuner_pkg::STATUS_ERROR_RATE_MASK},
        '{4'hb, 1'b0, 16'h0000, 16'hffff & ~tuner_pkg::CURRENT_CHANNEL_READBACK_ERROR_RATE_MASK}};
    // The device drives the data line only while its enable is high.
    assign sdio_line = sdio_oe ? sdio_out : host_sdio;
    tuner_power_regs #(.POWERUP_CYCLES(3), .POWERDOWN_CYCLES(2), .TIMER_WIDTH(16)) tuner_power_regs_inst (
        .clock(clock), .rst(rst), .serial_clock(serial_clock), .reset_pin_n(reset_pin_n),
        .serial_enable_pin_n(serial_enable_pin_n), .bus_strap_pin_one(strap_one), .bus_strap_pin_three(strap_three),
        .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .rds_status(rds_status),
        .powered_up(powered_up), .bus_two_wire(bus_two_wire), .audio_drive(audio_drive), .control_regs(control_regs));
    tuner_host_model tuner_host_model_inst (.serial_clock(serial_clock), .serial_enable_pin_n(serial_enable_pin_n),
        .host_sdio(host_sdio), .sdio_line(sdio_line));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // A wait that ran out ends the run at once.
    task automatic wait_ok(input logic ok);
        if (!ok) begin
            bad_count++;
            $display("ERROR wait expected 1 seen 0");
            tally_and_finish();
        end
    endtask : wait_ok
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        tuner_host_model_inst.xfer(1'b1, a, 16'h0000);
        v = tuner_host_model_inst.read_word;
    endtask : rd
    // Pulses the chip reset pin with the given straps held across its release.
    task automatic pin_cycle(input logic en, input logic one, input logic three);
        @(negedge clock);
        reset_pin_n = 1'b0;
        tuner_host_model_inst.set_enable(en);
        strap_one = one;
        strap_three = three;
        tuner_host_model_inst.park_high = three ? one : en;
        repeat (6) @(negedge clock);
        reset_pin_n = 1'b1;
        repeat (6) @(negedge clock);
        tuner_host_model_inst.set_enable(1'b1);
        repeat (40) @(negedge clock);
    endtask : pin_cycle
    initial begin
        logic [15:0] v;
        rst = 1'b1;
        reset_pin_n = 1'b0;
        strap_one = 1'b0;
        strap_three = 1'b0;
        bad_count = 0;
        tests_run = 0;
        rds_status = {16'hffff, 16'hffff, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
        repeat (8) @(negedge clock);
        rst = 1'b0;
        pin_cycle(1'b0, 1'b0, 1'b0);
        check("two_wire", 16'h0000, {15'h0, bus_two_wire});
        check("power_bits", 16'h0000, control_regs[2] & 16'h0041);
        $display("test straps done");
        foreach (rows[i]) begin
            if (rows[i].wr) tuner_host_model_inst.xfer(1'b0, rows[i].addr, rows[i].data);
            rd(rows[i].addr, v);
            check("read", rows[i].exp, v);
        end
        $display("test table done");
        tuner_host_model_inst.xfer(1'b0, 4'h7, 16'h0100);
        tuner_host_model_inst.xfer(1'b0, 4'h2, 16'h0801);
        for (int i = 0; i < 400 && powered_up !== 1'b1; i++) @(negedge clock);
        wait_ok(powered_up === 1'b1);
        check("audio_up", 16'h000a, {12'h000, audio_drive});
        rd(4'h1, v);
        check("revision_up", tuner_pkg::REVISION_UP_VALUE, v);
        rd(4'ha, v);
        check("status_verbose", 16'hffff, v);
        rd(4'h7, v);
        tuner_host_model_inst.xfer(1'b0, 4'h7, (v & 16'hc000) | 16'h7c04);
        check("audio_up_bias", 16'h000a, {12'h000, audio_drive});
        $display("test powerup done");
        tuner_host_model_inst.xfer(1'b0, 4'h4, 16'h0000);
        tuner_host_model_inst.xfer(1'b0, 4'h2, 16'h0841);
        for (int i = 0; i < 400 && control_regs[2][0] !== 1'b0; i++) @(negedge clock);
        check("power_word", 16'h0800, control_regs[2]);
        rd(4'h2, v);
        check("power_read", 16'h0800, v);
        check("audio_down", 16'h0005, {12'h000, audio_drive});
        rd(4'h7, v);
        tuner_host_model_inst.xfer(1'b0, 4'h7, (v & 16'hc000) | 16'h0100);
        rd(4'h3, v);
        check("kept", 16'h1234, v);
        $display("test powerdown done");
        pin_cycle(1'b1, 1'b0, 1'b0);
        check("cleared", 16'h0000, control_regs[3]);
        check("two_wire", 16'h0001, {15'h0, bus_two_wire});
        pin_cycle(1'b0, 1'b1, 1'b1);
        check("two_wire_m2", 16'h0001, {15'h0, bus_two_wire});
        pin_cycle(1'b1, 1'b0, 1'b1);
        check("three_wire_m2", 16'h0000, {15'h0, bus_two_wire});
        @(negedge clock);
        strap_one = 1'b1;
        repeat (10) @(negedge clock);
        check("strap_late", 16'h0000, {15'h0, bus_two_wire});
        $display("test reset pin done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
